// *** cts_pkg.sv ***
package cts_pkg;
  // ----------------------------------------
  // Bus levels
  // ----------------------------------------
  localparam logic LVL_DOMINANT  = 1'b0;
  localparam logic LVL_RECESSIVE = 1'b1;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ          = 40_000_000;
  localparam int BIT_RATE_MAX    = 1_000_000;
  localparam int BIT_CYCLES      = CLK_HZ / BIT_RATE_MAX;
  localparam int DOM_TIMEOUT_US  = 1000;
  localparam int BUS_TIMEOUT_US  = 1000;
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int ECHO_WAIT_CYC   = BIT_CYCLES;
  localparam int FOLLOW_FAILS    = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] FAIL_CNT_RST = 3'h0;

  // ----------------------------------------
  // Echo checker states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CTS_IDLE = 2'b00,
    CTS_WAIT = 2'b01,
    CTS_HOLD = 2'b11
  } cts_echo_t;
endpackage : cts_pkg

// *** cts_supervisor.sv ***
`timescale 1ns/100ps
module cts_supervisor
  import cts_pkg::*;
#(
  parameter int DOM_CYC  = cts_pkg::DOM_TIMEOUT_CYC,
  parameter int BUS_CYC  = cts_pkg::BUS_TIMEOUT_CYC,
  parameter int ECHO_CYC = cts_pkg::ECHO_WAIT_CYC
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Controller side
  input  wire logic ctl_tx,
  output logic      ctl_rx,
  // Bus driver and receiver
  input  wire logic bus_rx,
  output logic      bus_tx,
  // Fault control
  input  wire logic fault_handling_disable,
  input  wire logic clear_dom_timeout,
  input  wire logic clear_perm_recessive,
  input  wire logic clear_perm_dominant,
  input  wire logic clear_echo_fail,
  // Fault status
  output logic      fault_any,
  output logic      fault_dom_timeout,
  output logic      fault_perm_recessive,
  output logic      fault_perm_dominant,
  output logic      fault_echo_fail
);
  import cts_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] tx_sync;
  logic [1:0] rx_sync;
  logic       tx_s;
  logic       rx_s;
  logic       tx_prev;
  logic       tx_fall;

  // Two stages only; about two cycles of lag, far below a 1 Mbit/s bit
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      tx_sync <= {2{LVL_RECESSIVE}};
      rx_sync <= {2{LVL_RECESSIVE}};
      tx_prev <= LVL_RECESSIVE;
    end else begin
      tx_sync <= {tx_sync[0], ctl_tx};
      rx_sync <= {rx_sync[0], bus_rx};
      tx_prev <= tx_s;
    end
  end

  assign tx_s    = tx_sync[1];
  assign rx_s    = rx_sync[1];
  assign tx_fall = (tx_prev == LVL_RECESSIVE) && (tx_s == LVL_DOMINANT);

  // ----------------------------------------
  // Counter helper
  // ----------------------------------------
  function automatic logic [31:0] sat_inc(input logic [31:0] v, input int lim);
    sat_inc = (v >= 32'(lim)) ? v : v + 32'h1;
  endfunction

  logic tx_off;
  assign tx_off = fault_dom_timeout | fault_perm_recessive | fault_echo_fail;

  // ----------------------------------------
  // Dominant transmit timeout
  // ----------------------------------------
  logic [31:0] dom_cnt;

  always_ff @(posedge core_clk) begin
    if (!rst_b || tx_s == LVL_RECESSIVE) begin
      dom_cnt <= 32'h0;
    end else begin
      dom_cnt <= sat_inc(dom_cnt, DOM_CYC);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fault_dom_timeout <= 1'b0;
    end else if (!fault_handling_disable && dom_cnt >= 32'(DOM_CYC)) begin
      fault_dom_timeout <= 1'b1;
    end else if (clear_dom_timeout) begin
      fault_dom_timeout <= 1'b0;
    end
  end

  // ----------------------------------------
  // Permanent dominant bus
  // ----------------------------------------
  logic [31:0] bus_cnt;

  always_ff @(posedge core_clk) begin
    if (!rst_b || rx_s == LVL_RECESSIVE) begin
      bus_cnt <= 32'h0;
    end else begin
      bus_cnt <= sat_inc(bus_cnt, BUS_CYC);
    end
  end

  // Does not feed tx_off: transmitter stays on
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fault_perm_dominant <= 1'b0;
    end else if (!fault_handling_disable && bus_cnt >= 32'(BUS_CYC)) begin
      fault_perm_dominant <= 1'b1;
    end else if (clear_perm_dominant) begin
      fault_perm_dominant <= 1'b0;
    end
  end

  // ----------------------------------------
  // Follow checks on a dominant transmit edge taken while idle and not blocked
  // ----------------------------------------
  cts_echo_t   echo_st;
  logic [31:0] echo_cnt;
  logic        bus_seen;
  logic        echo_seen;
  logic [2:0]  bus_fails;
  logic [2:0]  echo_fails;
  logic        win_end;

  // Bus follow is judged on the receiver, echo on what reaches the controller
  assign win_end = (echo_st == CTS_WAIT) && (echo_cnt >= 32'(ECHO_CYC));

  // Trips on the fourth failure itself, or on a count left full while disabled;
  // a clear beats only the stale count, so one clear pulse rearms the path
  function automatic logic follow_trip(input logic ev, input logic [2:0] n, input logic clr);
    follow_trip = (ev && n == 3'(FOLLOW_FAILS - 1)) || (n >= 3'(FOLLOW_FAILS) && !clr);
  endfunction

  logic bus_fail_ev;
  logic echo_fail_ev;
  logic bus_trip;
  logic echo_trip;

  // Window closed with no dominant seen
  assign bus_fail_ev  = win_end && !bus_seen && rx_s != LVL_DOMINANT;
  assign echo_fail_ev = win_end && !echo_seen && ctl_rx != LVL_DOMINANT;
  assign bus_trip     = follow_trip(bus_fail_ev, bus_fails, clear_perm_recessive);
  assign echo_trip    = follow_trip(echo_fail_ev, echo_fails, clear_echo_fail);

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      echo_st   <= CTS_IDLE;
      echo_cnt  <= 32'h0;
      bus_seen  <= 1'b0;
      echo_seen <= 1'b0;
    end else begin
      case (echo_st)
        CTS_IDLE: begin
          if (tx_fall && !tx_off) begin
            echo_st   <= CTS_WAIT;
            echo_cnt  <= 32'h0;
            bus_seen  <= 1'b0;
            echo_seen <= 1'b0;
          end
        end
        CTS_WAIT: begin
          echo_cnt <= sat_inc(echo_cnt, ECHO_CYC);
          if (rx_s == LVL_DOMINANT) begin
            bus_seen <= 1'b1;
          end
          if (ctl_rx == LVL_DOMINANT) begin
            echo_seen <= 1'b1;
          end
          if (win_end) begin
            echo_st <= CTS_HOLD;
          end
        end
        CTS_HOLD: begin
          if (tx_s == LVL_RECESSIVE) begin
            echo_st <= CTS_IDLE;
          end
        end
        default: begin
          echo_st <= CTS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || clear_perm_recessive) begin
      bus_fails <= FAIL_CNT_RST;
    end else if (bus_fail_ev && bus_fails < 3'(FOLLOW_FAILS)) begin
      bus_fails <= bus_fails + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || clear_echo_fail) begin
      echo_fails <= FAIL_CNT_RST;
    end else if (echo_fail_ev && echo_fails < 3'(FOLLOW_FAILS)) begin
      echo_fails <= echo_fails + 3'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      fault_perm_recessive <= 1'b0;
      fault_echo_fail      <= 1'b0;
    end else begin
      if (!fault_handling_disable && bus_trip) begin
        fault_perm_recessive <= 1'b1;
      end else if (clear_perm_recessive) begin
        fault_perm_recessive <= 1'b0;
      end
      if (!fault_handling_disable && echo_trip) begin
        fault_echo_fail <= 1'b1;
      end else if (clear_echo_fail) begin
        fault_echo_fail <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Data paths and common flag
  // ----------------------------------------
  // Registered paths add a few 25 ns cycles, small against a 1 us bit
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bus_tx    <= LVL_RECESSIVE;
      ctl_rx    <= LVL_RECESSIVE;
      fault_any <= 1'b0;
    end else begin
      bus_tx    <= tx_off ? LVL_RECESSIVE : tx_s;
      ctl_rx    <= rx_s;
      fault_any <= tx_off | fault_perm_dominant;
    end
  end
endmodule // cts_supervisor

// *** cts_supervisor_monitor.sv ***
`timescale 1ns/100ps
module cts_supervisor_monitor
  import cts_pkg::*;
(
  // Watched ports
  input wire logic core_clk, rst_b, ctl_tx, ctl_rx, bus_rx, bus_tx,
  input wire logic fault_handling_disable, clear_perm_dominant, fault_any,
  input wire logic fault_dom_timeout, fault_perm_recessive, fault_perm_dominant,
  input wire logic fault_echo_fail
);
  logic [2:0] up;
  logic       blk;
  logic       anyf;
  assign blk  = fault_dom_timeout | fault_perm_recessive | fault_echo_fail;
  assign anyf = blk | fault_perm_dominant;
  // Reset history, so path checks never look back into a reset
  always_ff @(posedge core_clk) up <= {up[1:0], rst_b};
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_rst_rec; $rose(rst_b) |-> bus_tx && ctl_rx; endproperty
  a_rst_rec: assert property (p_rst_rec) else $error("bus not recessive after reset");
  property p_any; anyf |=> fault_any; endproperty
  a_any: assert property (p_any) else $error("common flag missing");
  property p_dis; $rose(anyf) |-> !$past(fault_handling_disable); endproperty
  a_dis: assert property (p_dis) else $error("flag set while disabled");
  property p_dom_blk; fault_dom_timeout |=> bus_tx; endproperty
  a_dom_blk: assert property (p_dom_blk) else $error("driver on after timeout");
  property p_fol_blk; fault_perm_recessive || fault_echo_fail |=> bus_tx; endproperty
  a_fol_blk: assert property (p_fol_blk) else $error("driver on after follow fault");
  property p_pd_hold; fault_perm_dominant && !clear_perm_dominant |=> fault_perm_dominant;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("dominant flag dropped");
  property p_tx; &up && !blk && !$past(blk) && !$past(blk, 2) |-> bus_tx == $past(ctl_tx, 3);
  endproperty
  a_tx: assert property (p_tx) else $error("transmit path wrong");
  property p_rx; &up |-> ctl_rx == $past(bus_rx, 3); endproperty
  a_rx: assert property (p_rx) else $error("receive path wrong");
  c_dom: cover property (fault_dom_timeout);
  c_fol: cover property (fault_perm_recessive && fault_echo_fail);
  c_pd: cover property (fault_perm_dominant && !bus_tx);
endmodule // cts_supervisor_monitor
bind cts_supervisor cts_supervisor_monitor mon_inst (.*);

// *** cts_bus_model.sv ***
`timescale 1ns/100ps
module cts_bus_model (
  // Bus lines
  input  wire logic bus_tx,
  input  wire logic stuck_rec,
  input  wire logic stuck_dom,
  output logic      bus_rx
);
  // Wired bus; stuck inputs emulate a clamped wire
  assign bus_rx = stuck_dom ? 1'h0 : (stuck_rec ? 1'h1 : bus_tx);
endmodule // cts_bus_model

// *** testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import cts_pkg::*;
  localparam int DC = 50;
  localparam int EC = 12;
  // Bus timeout kept apart from the transmit one so the two timeout faults are tested alone
  localparam int BC = 70;
  logic core_clk, rst_b, tx, rx, brx, btx, dis, sr, sd, cd, cr, cp, ce, fa, fd, fr, fp, fe;
  int n_mismatch = 0;
  int comparisons = 0;
  cts_supervisor #(.DOM_CYC(DC), .BUS_CYC(BC), .ECHO_CYC(EC)) cts_supervisor_inst (
    .core_clk(core_clk), .rst_b(rst_b), .ctl_tx(tx), .ctl_rx(rx), .bus_rx(brx),
    .bus_tx(btx), .fault_handling_disable(dis), .clear_dom_timeout(cd),
    .clear_perm_recessive(cr), .clear_perm_dominant(cp), .clear_echo_fail(ce),
    .fault_any(fa), .fault_dom_timeout(fd), .fault_perm_recessive(fr),
    .fault_perm_dominant(fp), .fault_echo_fail(fe));
  cts_bus_model cts_bus_model_inst (.bus_tx(btx), .stuck_rec(sr), .stuck_dom(sd), .bus_rx(brx));
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic clr;
    {cd, cr, cp, ce} = 4'hF;
    cyc(1);
    {cd, cr, cp, ce} = 4'h0;
    cyc(2);
  endtask
  task automatic t_dom;
    tx = 1'h0;
    cyc(DC + 8);
    chk("dom", 1'h1, fd);
    chk("any", 1'h1, fa);
    chk("btx", 1'h1, btx);
    tx = 1'h1;
    cyc(6);
    chk("dom", 1'h1, fd);
    clr();
    chk("dom", 1'h0, fd);
    tx = 1'h0;
    cyc(4);
    chk("btx", 1'h0, btx);
    tx = 1'h1;
    // Let the follow window close so the next dominant edge is seen
    cyc(EC + 8);
  endtask
  task automatic t_rec;
    sr = 1'h1;
    for (int i = 0; i < FOLLOW_FAILS; i++) begin
      chk("echo", 1'h0, fe);
      tx = 1'h0;
      cyc(EC + 10);
      tx = 1'h1;
      cyc(6);
    end
    chk("rec", 1'h1, fr);
    chk("echo", 1'h1, fe);
    tx = 1'h0;
    cyc(4);
    chk("btx", 1'h1, btx);
    tx = 1'h1;
    sr = 1'h0;
    cyc(4);
    clr();
    chk("echo", 1'h0, fe);
    chk("rec", 1'h0, fr);
  endtask
  task automatic t_pdom;
    sd = 1'h1;
    cyc(BC + 8);
    chk("pdom", 1'h1, fp);
    tx = 1'h0;
    cyc(4);
    chk("btx", 1'h0, btx);
    tx = 1'h1;
    sd = 1'h0;
    cyc(6);
    clr();
    chk("pdom", 1'h0, fp);
  endtask
  task automatic t_dis;
    dis = 1'h1;
    tx = 1'h0;
    cyc(DC + 8);
    chk("any", 1'h0, fa);
    chk("btx", 1'h0, btx);
    tx = 1'h1;
    cyc(8);
    dis = 1'h0;
    cyc(3);
    chk("any", 1'h0, fa);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst_b, dis, sr, sd, tx} = 5'h0;
    {cd, cr, cp, ce} = 4'h0;
    cyc(5);
    chk("btx", 1'h1, btx);
    rst_b = 1'h1;
    tx = 1'h1;
    cyc(4);
    tx = 1'h0;
    cyc(4);
    chk("btx", 1'h0, btx);
    cyc(3);
    chk("rx", 1'h0, rx);
    tx = 1'h1;
    cyc(7);
    chk("rx", 1'h1, rx);
    t_dom();
    t_rec();
    t_pdom();
    t_dis();
    report_and_stop();
  end
endmodule // testbench
